// [logic/viu_pkg.sv]
/*
 * Shared constants of the vector interrupt unit: request count, register
 * offsets, field positions, reset values and bus response codes.
 * Assumes an AXI4-Lite register bus with 32-bit data and byte addresses.
 */
package viu_pkg;
   localparam int REQ_COUNT = 56;
   localparam int PRIO_W = 4;
   localparam int IDX_W = 6;
   localparam int ADDR_W = 12;

   localparam logic [11:0] OFS_RAW_LO = 12'h000;
   localparam logic [11:0] OFS_RAW_HI = 12'h004;
   localparam logic [11:0] OFS_THR_FAST = 12'h010;
   localparam logic [11:0] OFS_THR_NORM = 12'h014;
   localparam logic [11:0] OFS_VEC_FAST = 12'h020;
   localparam logic [11:0] OFS_VEC_NORM = 12'h024;
   localparam logic [11:0] OFS_EVT_STAT = 12'h030;
   localparam logic [11:0] OFS_EVT_MASK = 12'h034;
   localparam logic [11:0] OFS_CFG_BASE = 12'h100;
   localparam logic [3:0] CFG_PAGE = 4'h1;

   localparam int CFG_PRIO_LSB = 0;
   localparam int CFG_TGT_BIT = 8;
   localparam int CFG_POL_BIT = 16;
   localparam int CFG_SWREQ_BIT = 24;
   localparam int VEC_VALID_BIT = 31;
   localparam int VEC_PRIO_LSB = 16;
   localparam int EVT_FAST_BIT = 0;
   localparam int EVT_NORM_BIT = 1;

   localparam logic TARGET_FAST = 1'h0;
   localparam logic TARGET_NORM = 1'h1;

   localparam logic [3:0] RST_PRIO = 4'h0;
   localparam logic [3:0] RST_THR = 4'h0;
   localparam logic [1:0] RST_EVT = 2'h0;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [logic/viu_prio_pick.sv]
/*
 * Priority picker for one target: finds the highest-priority candidate
 * request and its index. Purely combinational.
 * Assumes candidates with priority zero are already excluded.
 */
`timescale 1ns/1ns
module viu_prio_pick #(
   parameter int N = 56,
   parameter int PW = 4,
   parameter int IW = 6
) (
   // Candidates
   input wire logic [N-1:0] cand,
   input wire logic [N*PW-1:0] prioFlat,
   // Winner
   output logic found,
   output logic [PW-1:0] bestPrio,
   output logic [IW-1:0] bestIdx
);
   // Strictly greater keeps the lowest index on a tie
   always_comb begin
      found = 1'b0;
      bestPrio = '0;
      bestIdx = '0;
      for (int i = 0; i < N; i++) begin
         if (cand[i] && (!found || prioFlat[i*PW +: PW] > bestPrio)) begin
            found = 1'b1;
            bestPrio = prioFlat[i*PW +: PW];
            bestIdx = IW'(i);
         end
      end
   end
endmodule

// [logic/viu_vector_interrupt_unit.sv]
/*
 * Vector interrupt unit: routes level requests to the fast and normal
 * interrupt lines by priority and threshold, with an AXI4-Lite slave.
 * Assumes clk_sys is the unit's gated branch clock; branchClkOn low
 * stands for that clock being switched off.
 */
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
// Function
// RULE_01 - There are 56 level request inputs, each with a programmable active polarity.
// RULE_02 - Each request has a software request bit that raises it without the peripheral.
// RULE_03 - Software can read the raw state of each request after polarity and before masking.
// RULE_04 - Each request has a programmable priority choosing one of up to 15 active levels.
// RULE_05 - Software routes each request either to the fast or to the normal line.
// RULE_06 - Target value 0 selects the fast line and value 1 the normal line.
// RULE_07 - Each target has its own threshold against which request priority is compared.
// RULE_08 - A request of priority 0 is masked and never asserts either line.
// RULE_09 - Level 1 is lowest and 15 highest, and the higher value wins for a target.
// RULE_10 - A vector identifying the pending request is offered to software.
// RULE_11 - Nested servicing lets a higher priority request interrupt a lower one.
// RULE_12 - All logic runs on the branch clock and stops while it is switched off. Here only lines, vectors, event setting and bus readies stop.
// RULE_13 - A line is high while a routed active request has priority above its threshold.
module viu_vector_interrupt_unit #(
   parameter int REQ_N = viu_pkg::REQ_COUNT
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic branchClkOn,
   // Peripheral requests
   input wire logic [REQ_N-1:0] reqIn,
   // Processor lines
   output logic fastIrqLine,
   output logic normIrqLine,
   // Event interrupt
   output logic evtIrq,
   // AXI4-Lite write address
   input wire logic [viu_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [viu_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam int PW = viu_pkg::PRIO_W;
   localparam int IW = viu_pkg::IDX_W;
   localparam int AW = viu_pkg::ADDR_W;

   // Per-request configuration and evaluation
   logic [PW-1:0] prio [REQ_N];
   logic [REQ_N-1:0] target;
   logic [REQ_N-1:0] polInv;
   logic [REQ_N-1:0] swReq;
   logic [REQ_N-1:0] raw;
   logic [REQ_N-1:0] candFast;
   logic [REQ_N-1:0] candNorm;
   logic [REQ_N*PW-1:0] prioFlat;

   // Target state
   logic [PW-1:0] thrFast;
   logic [PW-1:0] thrNorm;
   logic [31:0] vecFast;
   logic [31:0] vecNorm;
   logic [1:0] evtStat;
   logic [1:0] evtMask;

   // Write channel holding
   logic awHave;
   logic wHave;
   logic [AW-1:0] wrAddr;
   logic [31:0] wrData;
   logic [3:0] wrStrb;

   // Picker results
   wire logic foundFast;
   wire logic foundNorm;
   wire logic [PW-1:0] bestPrioFast;
   wire logic [PW-1:0] bestPrioNorm;
   wire logic [IW-1:0] bestIdxFast;
   wire logic [IW-1:0] bestIdxNorm;

   // Write decode
   wire logic wrFire = awHave && wHave && !s_axi_bvalid;
   wire logic wrIsCfg = wrAddr[11:8] == viu_pkg::CFG_PAGE &&
      wrAddr[7:2] < IW'(REQ_N);
   wire logic [IW-1:0] wrCfgIdx = wrAddr[7:2];
   wire logic wrThrFast = wrAddr == viu_pkg::OFS_THR_FAST;
   wire logic wrThrNorm = wrAddr == viu_pkg::OFS_THR_NORM;
   wire logic wrStat = wrAddr == viu_pkg::OFS_EVT_STAT;
   wire logic wrMask = wrAddr == viu_pkg::OFS_EVT_MASK;
   wire logic wrRo = wrAddr == viu_pkg::OFS_RAW_LO ||
      wrAddr == viu_pkg::OFS_RAW_HI || wrAddr == viu_pkg::OFS_VEC_FAST ||
      wrAddr == viu_pkg::OFS_VEC_NORM;
   wire logic wrOk = wrIsCfg || wrThrFast || wrThrNorm || wrStat ||
      wrMask || wrRo;
   wire logic [1:0] evtClr = (wrFire && wrStat && wrStrb[0]) ?
      wrData[1:0] : 2'h0;

   // Request evaluation per entry
   genvar g;
   generate
      for (g = 0; g < REQ_N; g++) begin : gEntry
         wire logic prioOn;
         wire logic cfgSel;
         assign raw[g] = (reqIn[g] ^ polInv[g]) | swReq[g]; // RULE_01 RULE_02
         assign prioOn = prio[g] != viu_pkg::RST_PRIO; // RULE_08
         assign candFast[g] = raw[g] && prioOn &&
            target[g] == viu_pkg::TARGET_FAST; // RULE_05 RULE_06
         assign candNorm[g] = raw[g] && prioOn &&
            target[g] == viu_pkg::TARGET_NORM; // RULE_05 RULE_06
         assign prioFlat[g*PW +: PW] = prio[g];
         assign cfgSel = wrFire && wrIsCfg && wrCfgIdx == IW'(g);
         always_ff @(posedge clk_sys or posedge sys_rst) begin
            if (sys_rst) begin
               prio[g] <= viu_pkg::RST_PRIO;
               target[g] <= viu_pkg::TARGET_FAST;
               polInv[g] <= 1'b0;
               swReq[g] <= 1'b0;
            end else if (cfgSel) begin
               if (wrStrb[0]) begin
                  prio[g] <= wrData[viu_pkg::CFG_PRIO_LSB +: PW]; // RULE_04
               end
               if (wrStrb[1]) begin
                  target[g] <= wrData[viu_pkg::CFG_TGT_BIT]; // RULE_05
               end
               if (wrStrb[2]) begin
                  polInv[g] <= wrData[viu_pkg::CFG_POL_BIT]; // RULE_01
               end
               if (wrStrb[3]) begin
                  swReq[g] <= wrData[viu_pkg::CFG_SWREQ_BIT]; // RULE_02
               end
            end
         end
      end
   endgenerate

   viu_prio_pick #(.N(REQ_N), .PW(PW), .IW(IW)) uPickFast (
      .cand(candFast),
      .prioFlat(prioFlat),
      .found(foundFast),
      .bestPrio(bestPrioFast),
      .bestIdx(bestIdxFast)
   ); // RULE_09

   viu_prio_pick #(.N(REQ_N), .PW(PW), .IW(IW)) uPickNorm (
      .cand(candNorm),
      .prioFlat(prioFlat),
      .found(foundNorm),
      .bestPrio(bestPrioNorm),
      .bestIdx(bestIdxNorm)
   ); // RULE_09

   // Threshold compare; raising a threshold to the serviced level nests
   wire logic next_fastLine = foundFast && bestPrioFast > thrFast; // RULE_07 RULE_13 RULE_11
   wire logic next_normLine = foundNorm && bestPrioNorm > thrNorm; // RULE_07 RULE_13 RULE_11
   wire logic [31:0] next_vecFast = {foundFast, 11'h000,
      bestPrioFast, 10'h000, bestIdxFast}; // RULE_10
   wire logic [31:0] next_vecNorm = {foundNorm, 11'h000,
      bestPrioNorm, 10'h000, bestIdxNorm}; // RULE_10
   wire logic [1:0] evtSet = {next_normLine & ~normIrqLine,
      next_fastLine & ~fastIrqLine};

   // Evaluation freezes with the branch clock off
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         fastIrqLine <= 1'b0;
         normIrqLine <= 1'b0;
         vecFast <= 32'h0000_0000;
         vecNorm <= 32'h0000_0000;
      end else if (branchClkOn) begin // RULE_12
         fastIrqLine <= next_fastLine;
         normIrqLine <= next_normLine;
         vecFast <= next_vecFast;
         vecNorm <= next_vecNorm;
      end
   end

   // Bus stalls while the branch clock is off
   assign s_axi_awready = !awHave && branchClkOn; // RULE_12
   assign s_axi_wready = !wHave && branchClkOn; // RULE_12
   assign s_axi_arready = !s_axi_rvalid && branchClkOn; // RULE_12

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         awHave <= 1'b0;
         wrAddr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awHave <= 1'b1;
         wrAddr <= {s_axi_awaddr[AW-1:2], 2'h0};
      end else if (wrFire) begin
         awHave <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         wHave <= 1'b0;
         wrData <= 32'h0000_0000;
         wrStrb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wHave <= 1'b1;
         wrData <= s_axi_wdata;
         wrStrb <= s_axi_wstrb;
      end else if (wrFire) begin
         wHave <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= viu_pkg::RESP_OKAY;
      end else if (wrFire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wrOk ? viu_pkg::RESP_OKAY : viu_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         thrFast <= viu_pkg::RST_THR;
         thrNorm <= viu_pkg::RST_THR;
         evtMask <= viu_pkg::RST_EVT;
      end else if (wrFire && wrStrb[0]) begin
         if (wrThrFast) begin
            thrFast <= wrData[PW-1:0]; // RULE_07
         end
         if (wrThrNorm) begin
            thrNorm <= wrData[PW-1:0]; // RULE_07
         end
         if (wrMask) begin
            evtMask <= wrData[1:0];
         end
      end
   end

   // A new line assertion in the clearing cycle is kept
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         evtStat <= viu_pkg::RST_EVT;
      end else begin
         evtStat <= (evtStat & ~evtClr) | (branchClkOn ? evtSet : 2'h0);
      end
   end

   assign evtIrq = |(evtStat & evtMask);

   // Read decode
   wire logic [AW-1:0] rdAddr = {s_axi_araddr[AW-1:2], 2'h0};
   wire logic rdIsCfg = rdAddr[11:8] == viu_pkg::CFG_PAGE &&
      rdAddr[7:2] < IW'(REQ_N);
   wire logic [IW-1:0] rdCfgIdx = rdAddr[7:2];
   wire logic [63:0] rawWide = 64'(raw);
   wire logic [31:0] cfgWord = rdIsCfg ? {7'h00, swReq[rdCfgIdx],
      7'h00, polInv[rdCfgIdx], 7'h00, target[rdCfgIdx],
      4'h0, prio[rdCfgIdx]} : 32'h0000_0000;
   logic [31:0] rdMux;
   logic rdOk;

   always_comb begin
      rdOk = 1'b1;
      rdMux = 32'h0000_0000;
      case (rdAddr)
         viu_pkg::OFS_RAW_LO: rdMux = rawWide[31:0]; // RULE_03
         viu_pkg::OFS_RAW_HI: rdMux = rawWide[63:32]; // RULE_03
         viu_pkg::OFS_THR_FAST: rdMux = 32'(thrFast);
         viu_pkg::OFS_THR_NORM: rdMux = 32'(thrNorm);
         viu_pkg::OFS_VEC_FAST: rdMux = vecFast; // RULE_10
         viu_pkg::OFS_VEC_NORM: rdMux = vecNorm; // RULE_10
         viu_pkg::OFS_EVT_STAT: rdMux = 32'(evtStat);
         viu_pkg::OFS_EVT_MASK: rdMux = 32'(evtMask);
         default: begin
            rdMux = cfgWord;
            rdOk = rdIsCfg;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= viu_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdMux;
         s_axi_rresp <= rdOk ? viu_pkg::RESP_OKAY : viu_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// [bench/viu_monitor.sv]
/* Checker of bus handshakes and line freezing of the interrupt unit.
   Sees only the unit's ports; bound into every instance below. */
`timescale 1ns/1ns
module viu_monitor (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic branchClkOn,
   // Lines
   input wire logic fastIrqLine,
   input wire logic normIrqLine,
   // Bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   property p_rd_ans;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
   property p_rd_hold;
      s_axi_rvalid && !s_axi_rready |=>
         s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_wr_ans;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
         !s_axi_bvalid |=> ##1 s_axi_bvalid;
   endproperty
   a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
   property p_wr_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("response moved");
   property p_wr_busy;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   a_wr_busy: assert property (p_wr_busy) else $error("response repeated");
   property p_err_zero;
      s_axi_rvalid && s_axi_rresp == viu_pkg::RESP_SLVERR |-> s_axi_rdata == 0;
   endproperty
   a_err_zero: assert property (p_err_zero) else $error("error read data");
   property p_clk_off;
      !branchClkOn |-> !s_axi_awready && !s_axi_wready && !s_axi_arready;
   endproperty
   a_clk_off: assert property (p_clk_off) else $error("bus taken off");
   property p_freeze;
      !branchClkOn |=> $stable(fastIrqLine) && $stable(normIrqLine);
   endproperty
   a_freeze: assert property (p_freeze) else $error("line moved off");
   cover property (fastIrqLine && normIrqLine);
   cover property (s_axi_rvalid && s_axi_rresp == viu_pkg::RESP_SLVERR);
   cover property (!branchClkOn && fastIrqLine);
endmodule
bind viu_vector_interrupt_unit viu_monitor u_mon (.clk_sys, .sys_rst,
   .branchClkOn, .fastIrqLine, .normIrqLine, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .s_axi_rready);

// [bench/viu_cpu_model.sv]
/* Processor side model: counts entries into fast and normal service.
   Assumes the lines are levels synchronous to the unit's clock. */
`timescale 1ns/1ns
module viu_cpu_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic sys_rst,
   // Interrupt lines
   input wire logic fastIrqLine,
   input wire logic normIrqLine,
   // Service entries
   output logic [7:0] fastCnt,
   output logic [7:0] normCnt
);
   logic fastOld, normOld;
   // Separate counts: fast service may preempt normal service
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         fastOld <= 1'h0;
         normOld <= 1'h0;
         fastCnt <= 8'h00;
         normCnt <= 8'h00;
      end else begin
         fastOld <= fastIrqLine;
         normOld <= normIrqLine;
         if (fastIrqLine && !fastOld) fastCnt <= fastCnt + 8'h01;
         if (normIrqLine && !normOld) normCnt <= normCnt + 8'h01;
      end
   end
endmodule

// [bench/tb.sv]
/* Self-checking bench of the interrupt unit over AXI4-Lite.
   Assumes the register map and response codes of the unit's package. */
`timescale 1ns/1ns
module tb;
   logic clk_sys = 0, sys_rst = 1, branchClkOn = 1;
   logic [55:0] reqIn = 56'h0;
   logic [11:0] awA = 12'h000, arA = 12'h000;
   logic [31:0] wD = 32'h0000_0000, q, e;
   logic awV = 0, wV = 0, bR = 0, arV = 0, rR = 0;
   logic fastL, normL, evtIrq, awRdy, wRdy, bV, arRdy, rV, aT, wT, done;
   logic [1:0] bResp, rResp;
   logic [31:0] rD;
   logic [7:0] fastCnt, normCnt;
   logic [15:0] entExp;
   logic [3:0] prio [56];
   logic [3:0] thr [2];
   logic tgt [56], pol [56], sw [56];
   int bad_count = 0, comparisons = 0, cyc = 0;
   viu_vector_interrupt_unit DUT (.clk_sys, .sys_rst, .branchClkOn, .reqIn,
      .fastIrqLine(fastL), .normIrqLine(normL), .evtIrq, .s_axi_awaddr(awA),
      .s_axi_awvalid(awV), .s_axi_awready(awRdy), .s_axi_wdata(wD),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wV), .s_axi_wready(wRdy),
      .s_axi_bresp(bResp), .s_axi_bvalid(bV), .s_axi_bready(bR),
      .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arRdy),
      .s_axi_rdata(rD), .s_axi_rresp(rResp), .s_axi_rvalid(rV),
      .s_axi_rready(rR));
   viu_cpu_model cpu (.clk_sys, .sys_rst, .fastIrqLine(fastL),
      .normIrqLine(normL), .fastCnt, .normCnt);
   initial begin
      forever #20 clk_sys = ~clk_sys;
   end
   task automatic report_and_stop;
      if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         bad_count++;
         report_and_stop;
      end
   end
   task automatic chk(input string n, input logic [31:0] x, y);
      comparisons++;
      if (y !== x) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, x, y);
      end
   endtask
   // Handshake outcome is decided at the falling edge, where all is settled
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
         input logic [1:0] r);
      @(posedge clk_sys);
      awA <= a;
      wD <= d;
      awV <= 1;
      wV <= 1;
      bR <= 1;
      done = 0;
      while (!done) begin
         @(negedge clk_sys);
         aT = awV && awRdy;
         wT = wV && wRdy;
         done = bV;
         if (done) chk("bresp", r, bResp);
         @(posedge clk_sys);
         if (aT) awV <= 0;
         if (wT) wV <= 0;
         if (done) bR <= 0;
      end
   endtask
   task automatic rd(input logic [11:0] a, input logic [1:0] r);
      @(posedge clk_sys);
      arA <= a;
      arV <= 1;
      rR <= 1;
      done = 0;
      while (!done) begin
         @(negedge clk_sys);
         aT = arV && arRdy;
         done = rV;
         q = rD;
         if (done) chk("rresp", r, rResp);
         @(posedge clk_sys);
         if (aT) arV <= 0;
         if (done) rR <= 0;
      end
   endtask
   function automatic logic act(input int i);
      return (reqIn[i] ^ pol[i]) | sw[i];
   endfunction
   function automatic logic [31:0] vecExp(input int t);
      logic [31:0] v;
      v = 32'h0000_0000;
      for (int i = 0; i < 56; i++)
         if (act(i) && prio[i] != 4'h0 && tgt[i] == t[0]
               && (!v[31] || prio[i] > v[19:16]))
            v = {1'h1, 11'h000, prio[i], 10'h000, i[5:0]};
      return v;
   endfunction
   function automatic logic lineExp(input int t);
      logic [31:0] v;
      v = vecExp(t);
      return v[31] && v[19:16] > thr[t];
   endfunction
   task automatic cfg(input int i);
      wr(viu_pkg::OFS_CFG_BASE + 12'(4 * i), {7'h00, sw[i], 7'h00, pol[i],
         7'h00, tgt[i], 4'h0, prio[i]}, viu_pkg::RESP_OKAY);
   endtask
   task automatic setThr(input int t, input logic [3:0] v);
      thr[t] = v;
      wr(t ? viu_pkg::OFS_THR_NORM : viu_pkg::OFS_THR_FAST, {28'h0, v},
         viu_pkg::RESP_OKAY);
   endtask
   task automatic checkAll;
      logic [55:0] raw;
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      for (int i = 0; i < 56; i++) raw[i] = act(i);
      chk("fastLine", lineExp(0), fastL);
      chk("normLine", lineExp(1), normL);
      rd(viu_pkg::OFS_RAW_LO, viu_pkg::RESP_OKAY);
      chk("rawLo", raw[31:0], q);
      rd(viu_pkg::OFS_RAW_HI, viu_pkg::RESP_OKAY);
      chk("rawHi", {8'h00, raw[55:32]}, q);
      for (int t = 0; t < 2; t++) begin
         e = vecExp(t);
         rd(t ? viu_pkg::OFS_VEC_NORM : viu_pkg::OFS_VEC_FAST,
            viu_pkg::RESP_OKAY);
         chk("vector", e, q);
      end
   endtask
   initial begin
      void'($urandom(32'h238f));
      for (int i = 0; i < 56; i++) {prio[i], tgt[i], pol[i], sw[i]} = 7'h00;
      thr = '{4'h0, 4'h0};
      repeat (2) @(posedge clk_sys);
      sys_rst <= 0;
      rd(viu_pkg::OFS_THR_NORM, viu_pkg::RESP_OKAY);
      chk("thrReset", 32'h0000_0000, q);
      rd(viu_pkg::OFS_CFG_BASE + 12'h0dc, viu_pkg::RESP_OKAY);
      chk("cfgReset", 32'h0000_0000, q);
      rd(12'h040, viu_pkg::RESP_SLVERR);
      chk("unmapped", 32'h0000_0000, q);
      wr(12'h040, 32'hffff_ffff, viu_pkg::RESP_SLVERR);
      checkAll;
      repeat (8) begin
         for (int i = 0; i < 56; i++) begin
            {prio[i], tgt[i], pol[i]} = 6'($urandom);
            sw[i] = $urandom % 8 == 0;
            cfg(i);
         end
         setThr(0, 4'($urandom));
         setThr(1, 4'($urandom));
         @(posedge clk_sys);
         reqIn <= 56'({$urandom, $urandom});
         checkAll;
      end
      // Top threshold lets no priority through, as in nested service
      setThr(0, 4'hf);
      setThr(1, 4'hf);
      checkAll;
      for (int i = 0; i < 56; i++) begin
         {prio[i], tgt[i], pol[i], sw[i]} = {4'hf, i == 1, 2'h0};
         if (i > 1) prio[i] = 4'h0;
         cfg(i);
      end
      wr(viu_pkg::OFS_EVT_STAT, 32'h0000_0003, viu_pkg::RESP_OKAY);
      wr(viu_pkg::OFS_EVT_MASK, 32'h0000_0003, viu_pkg::RESP_OKAY);
      @(posedge clk_sys);
      reqIn <= 56'h3;
      @(negedge clk_sys);
      chk("evtIrq", 32'h0, evtIrq);
      entExp = {fastCnt + 8'h01, normCnt + 8'h01};
      setThr(0, 4'he);
      setThr(1, 4'he);
      checkAll;
      chk("cpuEntries", 32'(entExp), {16'h0000, fastCnt, normCnt});
      chk("evtIrq", 32'h1, evtIrq);
      rd(viu_pkg::OFS_EVT_STAT, viu_pkg::RESP_OKAY);
      chk("evtStat", 32'h0000_0003, q);
      wr(viu_pkg::OFS_EVT_MASK, 32'h0000_0000, viu_pkg::RESP_OKAY);
      @(negedge clk_sys);
      chk("evtIrq", 32'h0, evtIrq);
      wr(viu_pkg::OFS_EVT_STAT, 32'h0000_0003, viu_pkg::RESP_OKAY);
      rd(viu_pkg::OFS_EVT_STAT, viu_pkg::RESP_OKAY);
      chk("evtStat", 32'h0000_0000, q);
      @(posedge clk_sys);
      branchClkOn <= 0;
      reqIn <= 56'h0;
      repeat (3) @(negedge clk_sys);
      chk("fastFrozen", 32'h1, fastL);
      chk("normFrozen", 32'h1, normL);
      @(posedge clk_sys);
      branchClkOn <= 1;
      checkAll;
      pol[0] = 1;
      cfg(0);
      checkAll;
      report_and_stop;
   end
endmodule
